// file: core/bpsc_ctl.v
// Protocol operation control, sync accounting and startup control.
//
// Function
// R1: Damped rate correction reads zero in the 12-bit display field.
// R2: Correction inside the damping range is applied as zero.
// R3: Initial zero rate correction adjusts no earlier than three cycles later.
// R4: Startup frames after more than the sync maximum are not counted.
// R5: Sync overflow is not raised from slot counter reaching 1023 plus maximum.
// R6: Late idle stops slot counting and sending for the segment.
// R7: Prescaler 00 is 10 Mbit/s; loop back valid only there.
// R8: Offset beyond limit after first even/odd pair enters abort startup.
// R9: Valid wakeup pattern in listen goes ready and updates wakeup status.
// R10: Continued pattern flags again at second following symbol.
// R11: Ready command in ready is accepted and sets coldstart inhibit.
// R12: Allow coldstart code 1001 clears coldstart inhibit.
// R13: Slot mode holds after halt or freeze until halt to default config.
// R14: Loop back entered from config starts acceptance filtering.
// R15: Host places startup frames first and sets sync maximum high enough.
// R16: Host programs initial offset one rather than zero.
// R17: Host leaves halt by reset before loop back after freeze or halt.
// R18: Commands invalid in the current state are ignored.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "bpsc_regs.vh"
module bpsc_ctl #(
    parameter RCW = 12,
    parameter SLOTW = 11,
    parameter SYNCW = 4
) (
    // Clock, enable and reset.
    input wire clock,
    input wire srst,
    input wire ce,
    // Register port.
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    // Protocol events from the bus side.
    input wire cycle_start,
    input wire even_cycle,
    input wire sync_frame_rx,
    input wire startup_frame_rx,
    input wire dyn_slot_tick,
    input wire dyn_seg_end,
    input wire idle_late,
    input wire rc_calc_valid,
    input wire [RCW-1:0] rc_calc_value,
    input wire pair_done,
    input wire offset_over_limit,
    input wire startup_done,
    input wire [1:0] wus_rx,
    input wire [1:0] slot_mode_in,
    // Protocol outputs.
    output reg [3:0] poc_state,
    output wire [RCW-1:0] rate_correction_value,
    output reg [SYNCW-1:0] startup_count,
    output reg tx_enable,
    output reg slot_count_en,
    output reg accept_filter_en,
    output reg [1:0] baud_prescaler,
    output reg loopback_valid,
    output wire irq
);
    ////////////////////////////////////////////////////////////////////////
    reg [3:0] poc_state_next;
    reg [2:0] wakeup_status_vector;
    reg coldstart_inhibit_status;
    reg [1:0] slot_mode_status;
    reg [`BPSC_IRQ_BITS-1:0] irq_stat_reg;
    reg [`BPSC_IRQ_BITS-1:0] irq_mask_reg;
    reg [`BPSC_IRQ_BITS-1:0] irq_set;
    reg [RCW-1:0] drift_damping_reg;
    reg [SYNCW-1:0] sync_max_reg;
    reg [SYNCW:0] sync_count_reg;
    reg [SLOTW-1:0] dyn_slot_reg;
    reg [1:0] rc_hold_reg;
    reg dyn_stop_reg;
    wire [1:0] wup_flag;
    wire cmd_wr;
    wire [3:0] cmd;
    wire leave_listen;
    assign cmd_wr = ce && wr && (addr == `BPSC_ADDR_CMD);
    assign cmd = wdata[3:0];
    assign irq = |(irq_stat_reg & irq_mask_reg);
    assign leave_listen = (poc_state == `BPSC_ST_WAKEUP_LISTEN) && (|wup_flag);

    ////////////////////////////////////////////////////////////////////////
    bpsc_rate_corr #(.W(RCW)) u_rc (
        .clock(clock),
        .srst(srst),
        .ce(ce),
        .calc_valid(rc_calc_valid && (rc_hold_reg == 2'h0)),
        .calc_value(rc_calc_value),
        .drift_damping(drift_damping_reg),
        .rate_correction_value(rate_correction_value)
    );

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_wu
            bpsc_wakeup_det u_wd (
                .clock(clock),
                .srst(srst),
                .ce(ce),
                .restart(leave_listen),
                .wus(wus_rx[ch]),
                .pattern(wup_flag[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // State transitions from host commands and protocol events.
    always @* begin
        poc_state_next = poc_state;
        if (cmd_wr) begin
            case (cmd)
                `BPSC_CMD_CONFIG: begin
                    if (poc_state == `BPSC_ST_DEFAULT_CONFIG || poc_state == `BPSC_ST_READY ||
                        poc_state == `BPSC_ST_LOOP_BACK)
                        poc_state_next = `BPSC_ST_CONFIG;
                    else if (poc_state == `BPSC_ST_HALT)
                        poc_state_next = `BPSC_ST_DEFAULT_CONFIG;
                end
                `BPSC_CMD_READY: begin
                    if (poc_state != `BPSC_ST_DEFAULT_CONFIG && poc_state != `BPSC_ST_HALT)
                        poc_state_next = `BPSC_ST_READY; // [R11]
                end
                `BPSC_CMD_WAKEUP: begin
                    if (poc_state == `BPSC_ST_READY)
                        poc_state_next = `BPSC_ST_WAKEUP_LISTEN;
                end
                `BPSC_CMD_RUN: begin
                    if (poc_state == `BPSC_ST_READY)
                        poc_state_next = `BPSC_ST_STARTUP;
                end
                `BPSC_CMD_HALT, `BPSC_CMD_FREEZE: begin
                    if (poc_state != `BPSC_ST_DEFAULT_CONFIG && poc_state != `BPSC_ST_CONFIG)
                        poc_state_next = `BPSC_ST_HALT;
                end
                `BPSC_CMD_LOOPBACK: begin
                    if (poc_state == `BPSC_ST_CONFIG)
                        poc_state_next = `BPSC_ST_LOOP_BACK;
                end
                default: poc_state_next = poc_state; // [R18]
            endcase
        end else begin
            case (poc_state)
                `BPSC_ST_WAKEUP_LISTEN: if (|wup_flag) poc_state_next = `BPSC_ST_READY; // [R9]
                `BPSC_ST_STARTUP: begin
                    if (pair_done && offset_over_limit)
                        poc_state_next = `BPSC_ST_ABORT_STARTUP; // [R8]
                    else if (startup_done)
                        poc_state_next = `BPSC_ST_NORMAL_ACTIVE;
                end
                `BPSC_ST_ABORT_STARTUP: poc_state_next = `BPSC_ST_STARTUP; // [R8]
                default: poc_state_next = poc_state;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always @* begin
        irq_set = {`BPSC_IRQ_BITS{1'b0}};
        irq_set[`BPSC_IRQ_WST] = leave_listen; // [R9]
        irq_set[`BPSC_IRQ_WUPA] = wup_flag[0]; // [R9] [R10]
        irq_set[`BPSC_IRQ_WUPB] = wup_flag[1]; // [R9] [R10]
        // Overflow comes from the sync count alone, never the slot counter.
        irq_set[`BPSC_IRQ_SFO] = sync_frame_rx && (sync_count_reg == {1'b0, sync_max_reg}); // [R5]
        irq_set[`BPSC_IRQ_ABORT] = (poc_state_next == `BPSC_ST_ABORT_STARTUP) &&
                                   (poc_state != `BPSC_ST_ABORT_STARTUP);
    end

    always @(posedge clock) begin
        if (srst) begin
            poc_state <= `BPSC_ST_DEFAULT_CONFIG;
            wakeup_status_vector <= 3'h0;
            coldstart_inhibit_status <= 1'b1;
            slot_mode_status <= `BPSC_SLM_SINGLE;
            irq_stat_reg <= {`BPSC_IRQ_BITS{1'b0}};
            irq_mask_reg <= {`BPSC_IRQ_BITS{1'b0}};
            drift_damping_reg <= {RCW{1'b0}};
            sync_max_reg <= {SYNCW{1'b1}};
            sync_count_reg <= {(SYNCW+1){1'b0}};
            startup_count <= {SYNCW{1'b0}};
            dyn_slot_reg <= {SLOTW{1'b0}};
            dyn_stop_reg <= 1'b0;
            rc_hold_reg <= 2'h0;
            baud_prescaler <= `BPSC_BRP_10M;
            accept_filter_en <= 1'b0;
            rdata <= 32'h00000000;
        end else if (ce) begin
            poc_state <= poc_state_next;
            if (leave_listen)
                wakeup_status_vector <= {1'b0, wup_flag}; // [R9]
            if (cmd_wr && cmd == `BPSC_CMD_READY && poc_state_next == `BPSC_ST_READY)
                coldstart_inhibit_status <= 1'b1; // [R11]
            else if (cmd_wr && cmd == `BPSC_CMD_ALLOW_COLDSTART && poc_state != `BPSC_ST_DEFAULT_CONFIG &&
                     poc_state != `BPSC_ST_CONFIG && poc_state != `BPSC_ST_HALT)
                coldstart_inhibit_status <= 1'b0; // [R12]
            // Slot mode is kept in halt and only cleared on the way out to default config.
            if (poc_state == `BPSC_ST_HALT && poc_state_next == `BPSC_ST_DEFAULT_CONFIG)
                slot_mode_status <= `BPSC_SLM_SINGLE; // [R13]
            else if (poc_state == `BPSC_ST_NORMAL_ACTIVE || poc_state == `BPSC_ST_NORMAL_PASSIVE)
                slot_mode_status <= slot_mode_in;
            // Sync and slot accounting restart each cycle, the startup count each even cycle.
            if (cycle_start) begin
                sync_count_reg <= {(SYNCW+1){1'b0}};
                if (even_cycle)
                    startup_count <= {SYNCW{1'b0}};
                dyn_slot_reg <= {SLOTW{1'b0}};
                dyn_stop_reg <= 1'b0;
            end else begin
                if (sync_frame_rx && sync_count_reg <= {1'b0, sync_max_reg})
                    sync_count_reg <= sync_count_reg + 1'b1;
                if (startup_frame_rx && even_cycle && sync_count_reg <= {1'b0, sync_max_reg})
                    startup_count <= startup_count + 1'b1; // [R4]
                if (dyn_slot_tick && !dyn_stop_reg)
                    dyn_slot_reg <= dyn_slot_reg + 1'b1;
                if (idle_late)
                    dyn_stop_reg <= 1'b1; // [R6]
                else if (dyn_seg_end)
                    dyn_stop_reg <= 1'b0;
            end
            // A fresh integration waits three cycles before taking a new correction.
            if (poc_state_next == `BPSC_ST_STARTUP && poc_state != `BPSC_ST_STARTUP)
                rc_hold_reg <= `BPSC_RC_ADJ_CYCLES; // [R3]
            else if (cycle_start && rc_hold_reg != 2'h0)
                rc_hold_reg <= rc_hold_reg - 2'h1; // [R3]
            if (poc_state_next == `BPSC_ST_LOOP_BACK)
                accept_filter_en <= 1'b1; // [R14]
            else if (poc_state_next != poc_state)
                accept_filter_en <= 1'b0;
            if (wr && addr == `BPSC_ADDR_CFG && poc_state == `BPSC_ST_CONFIG) begin
                baud_prescaler <= wdata[1:0]; // [R7]
                drift_damping_reg <= wdata[RCW+7:8];
            end
            if (wr && addr == `BPSC_ADDR_SYNC && poc_state == `BPSC_ST_CONFIG)
                sync_max_reg <= wdata[SYNCW-1:0];
            if (wr && addr == `BPSC_ADDR_IRQ_MASK)
                irq_mask_reg <= wdata[`BPSC_IRQ_BITS-1:0];
            if (rd && addr == `BPSC_ADDR_IRQ_STAT)
                irq_stat_reg <= irq_set;
            else
                irq_stat_reg <= irq_stat_reg | irq_set;
            rdata <= 32'h00000000;
            if (rd) begin
                case (addr)
                    `BPSC_ADDR_STAT: rdata <= {22'h0, wakeup_status_vector, coldstart_inhibit_status,
                                               slot_mode_status, poc_state};
                    `BPSC_ADDR_RCV: rdata <= {{(32-RCW){1'b0}}, rate_correction_value}; // [R1]
                    `BPSC_ADDR_CFG: rdata <= {{(24-RCW){1'b0}}, drift_damping_reg, 6'h0, baud_prescaler};
                    `BPSC_ADDR_IRQ_STAT: rdata <= {{(32-`BPSC_IRQ_BITS){1'b0}}, irq_stat_reg};
                    `BPSC_ADDR_IRQ_MASK: rdata <= {{(32-`BPSC_IRQ_BITS){1'b0}}, irq_mask_reg};
                    `BPSC_ADDR_SYNC: rdata <= {{(16-SYNCW){1'b0}}, startup_count, {(16-SYNCW){1'b0}}, sync_max_reg};
                    default: rdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Late idle silences the node for the rest of the segment.
    always @* begin
        tx_enable = (poc_state == `BPSC_ST_NORMAL_ACTIVE || poc_state == `BPSC_ST_STARTUP) &&
                    !dyn_stop_reg; // [R6]
        slot_count_en = !dyn_stop_reg; // [R6]
        loopback_valid = (poc_state == `BPSC_ST_LOOP_BACK) && (baud_prescaler == `BPSC_BRP_10M); // [R7]
    end
endmodule // bpsc_ctl

// file: pkg/bpsc_regs.vh
// Register offsets, field positions, reset values and command codes of the protocol control block.
`ifndef BPSC_REGS_VH
`define BPSC_REGS_VH
`define BPSC_ADDR_CMD 4'h0
`define BPSC_ADDR_STAT 4'h1
`define BPSC_ADDR_RCV 4'h2
`define BPSC_ADDR_CFG 4'h3
`define BPSC_ADDR_IRQ_STAT 4'h4
`define BPSC_ADDR_IRQ_MASK 4'h5
`define BPSC_ADDR_SYNC 4'h6
`define BPSC_CMD_READY 4'h2
`define BPSC_CMD_WAKEUP 4'h3
`define BPSC_CMD_RUN 4'h4
`define BPSC_CMD_HALT 4'h6
`define BPSC_CMD_FREEZE 4'h7
`define BPSC_CMD_CONFIG 4'h1
`define BPSC_CMD_LOOPBACK 4'h8
`define BPSC_CMD_ALLOW_COLDSTART 4'h9
`define BPSC_ST_DEFAULT_CONFIG 4'h0
`define BPSC_ST_CONFIG 4'h1
`define BPSC_ST_READY 4'h2
`define BPSC_ST_WAKEUP_LISTEN 4'h3
`define BPSC_ST_STARTUP 4'h4
`define BPSC_ST_NORMAL_ACTIVE 4'h5
`define BPSC_ST_NORMAL_PASSIVE 4'h6
`define BPSC_ST_HALT 4'h7
`define BPSC_ST_LOOP_BACK 4'h8
`define BPSC_ST_ABORT_STARTUP 4'h9
`define BPSC_SLM_SINGLE 2'h0
`define BPSC_BRP_10M 2'h0
`define BPSC_IRQ_WST 0
`define BPSC_IRQ_WUPA 1
`define BPSC_IRQ_WUPB 2
`define BPSC_IRQ_SFO 3
`define BPSC_IRQ_ABORT 4
`define BPSC_IRQ_BITS 5
`define BPSC_SLOT_OVF_BASE 11'h3FF
`define BPSC_RC_ADJ_CYCLES 2'h3
`endif

// file: core/bpsc_rate_corr.v
// Rate correction damping and display value.
`timescale 1ns/10ps
module bpsc_rate_corr #(
    parameter W = 12
) (
    // Clock and control.
    input wire clock,
    input wire srst,
    input wire ce,
    // Calculation result.
    input wire calc_valid,
    input wire [W-1:0] calc_value,
    input wire [W-1:0] drift_damping,
    // Applied and displayed value.
    output reg [W-1:0] rate_correction_value
);
    wire signed [W-1:0] v;
    wire signed [W-1:0] d;
    wire in_damp;
    assign v = calc_value;
    assign d = drift_damping;
    // Values within the damping band are applied and displayed as zero.
    assign in_damp = (v <= d) && (v >= -d); // [R1] [R2]
    always @(posedge clock) begin
        if (srst) begin
            rate_correction_value <= {W{1'b0}};
        end else if (ce && calc_valid) begin
            rate_correction_value <= in_damp ? {W{1'b0}} : calc_value; // [R1] [R2]
        end
    end
endmodule // bpsc_rate_corr

// file: core/bpsc_wakeup_det.v
// Wakeup symbol counter producing a pattern flag every second symbol.
`timescale 1ns/10ps
module bpsc_wakeup_det (
    // Clock and control.
    input wire clock,
    input wire srst,
    input wire ce,
    input wire restart,
    // Symbol seen on this channel.
    input wire wus,
    // Pattern detected.
    output wire pattern
);
    reg odd_reg;
    // The ready move restarts counting unless a symbol lands with it, so flags land every second symbol.
    assign pattern = wus && odd_reg; // [R10]
    always @(posedge clock) begin
        if (srst) begin
            odd_reg <= 1'b0;
        end else if (ce) begin
            if (wus) begin
                odd_reg <= ~odd_reg;
            end else if (restart) begin
                odd_reg <= 1'b0;
            end
        end
    end
endmodule // bpsc_wakeup_det

// file: tb/bpsc_ctl_chk.sv
// Port checker for the protocol control block.
`timescale 1ns/10ps
`include "bpsc_regs.vh"
module bpsc_ctl_chk #(
    parameter RCW = 12,
    parameter SYNCW = 4
) (
    // Clock and reset.
    input wire clock,
    input wire srst,
    // Register writes.
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    // Events.
    input wire cycle_start,
    input wire even_cycle,
    input wire sync_frame_rx,
    input wire startup_frame_rx,
    input wire idle_late,
    input wire rc_calc_valid,
    input wire [RCW-1:0] rc_calc_value,
    input wire pair_done,
    input wire offset_over_limit,
    // Outputs.
    input wire [3:0] poc_state,
    input wire [RCW-1:0] rate_correction_value,
    input wire [SYNCW-1:0] startup_count,
    input wire tx_enable,
    input wire slot_count_en,
    input wire accept_filter_en,
    input wire [1:0] baud_prescaler,
    input wire loopback_valid
);
    ////////////////////////////////////////////////////////////////////////////
    reg [RCW-1:0] damp_reg;
    reg [SYNCW-1:0] smax_reg;
    reg [7:0] sync_cnt_reg;
    reg [1:0] cs_cnt_reg;
    wire cfg_wr = wr && poc_state == `BPSC_ST_CONFIG;
    wire signed [RCW:0] calc_s = $signed({rc_calc_value[RCW-1], rc_calc_value});
    wire signed [RCW:0] damp_s = $signed({1'b0, damp_reg});
    wire in_rng = calc_s <= damp_s && calc_s >= -damp_s;
    always @(posedge clock) begin
        if (srst) begin
            damp_reg <= {RCW{1'b0}};
            smax_reg <= {SYNCW{1'b1}};
            sync_cnt_reg <= 8'h00;
            cs_cnt_reg <= 2'h0;
        end else begin
            if (cfg_wr && addr == `BPSC_ADDR_CFG) damp_reg <= wdata[19:8];
            if (cfg_wr && addr == `BPSC_ADDR_SYNC) smax_reg <= wdata[SYNCW-1:0];
            if (cycle_start) sync_cnt_reg <= 8'h00;
            else if (sync_frame_rx) sync_cnt_reg <= sync_cnt_reg + 8'h01;
            if (poc_state != `BPSC_ST_STARTUP) cs_cnt_reg <= 2'h0;
            else if (cycle_start && cs_cnt_reg != 2'h3) cs_cnt_reg <= cs_cnt_reg + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    property p_rc_damp;
        rc_calc_valid |=> $stable(rate_correction_value) ||
            rate_correction_value == ($past(in_rng) ? {RCW{1'b0}} : $past(rc_calc_value));
    endproperty
    a_rc_damp: assert property (p_rc_damp) else $error("rate correction not damped");
    property p_rc_hold;
        $past(rc_calc_valid) && $past(cs_cnt_reg) < 2'h2 && $past(poc_state) == `BPSC_ST_STARTUP
            |-> $stable(rate_correction_value);
    endproperty
    a_rc_hold: assert property (p_rc_hold) else $error("early rate correction");
    property p_startup_cnt;
        startup_frame_rx && even_cycle && sync_cnt_reg > smax_reg |=> $stable(startup_count);
    endproperty
    a_startup_cnt: assert property (p_startup_cnt) else $error("late startup frame counted");
    property p_idle_late;
        idle_late |=> !slot_count_en && !tx_enable;
    endproperty
    a_idle_late: assert property (p_idle_late) else $error("slot counting not stopped");
    property p_lb_rate;
        loopback_valid |-> baud_prescaler == `BPSC_BRP_10M;
    endproperty
    a_lb_rate: assert property (p_lb_rate) else $error("loop back valid at low rate");
    property p_abort;
        pair_done && offset_over_limit && poc_state == `BPSC_ST_STARTUP
            |-> ##[1:2] poc_state == `BPSC_ST_ABORT_STARTUP;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort on large offset");
    property p_wake_ready;
        $past(poc_state) == `BPSC_ST_WAKEUP_LISTEN && poc_state != `BPSC_ST_WAKEUP_LISTEN && !$past(wr)
            |-> poc_state == `BPSC_ST_READY;
    endproperty
    a_wake_ready: assert property (p_wake_ready) else $error("wakeup did not reach ready");
    property p_lb_filter;
        poc_state == `BPSC_ST_LOOP_BACK && $past(poc_state) == `BPSC_ST_LOOP_BACK |-> accept_filter_en;
    endproperty
    a_lb_filter: assert property (p_lb_filter) else $error("filtering off in loop back");
    c_loop: cover property (poc_state == `BPSC_ST_LOOP_BACK);
    c_idle: cover property (idle_late);
    c_abort: cover property (pair_done && offset_over_limit);
endmodule // bpsc_ctl_chk

// file: tb/bpsc_node_model.sv
// Far-side node that sends wakeup symbols separated by idle phases.
`timescale 1ns/10ps
module bpsc_node_model (
    // Clock and request.
    input wire clock,
    input wire start,
    input wire [1:0] chan,
    input wire [3:0] count,
    // Symbols and status.
    output reg [1:0] wus_rx,
    output wire busy
);
    reg [3:0] left_reg = 4'h0;
    reg [3:0] gap_reg = 4'h0;
    assign busy = left_reg != 4'h0;
    initial wus_rx = 2'h0;
    // An idle gap keeps each symbol a separate one at the receiver.
    always @(posedge clock) begin
        wus_rx <= 2'h0;
        if (start) begin
            left_reg <= count;
            gap_reg <= 4'h0;
        end else if (busy && gap_reg == 4'h0) begin
            wus_rx <= chan;
            left_reg <= left_reg - 4'h1;
            gap_reg <= 4'h6;
        end else if (busy) begin
            gap_reg <= gap_reg - 4'h1;
        end
    end
endmodule // bpsc_node_model

// file: tb/bus_protocol_sync_startup_ctl_bench.sv
// Self-checking bench for the protocol control block.
`timescale 1ns/10ps
`include "bpsc_regs.vh"
module bus_protocol_sync_startup_ctl_bench;
    reg clock = 1'b0;
    reg srst = 1'b1;
    reg [3:0] addr = 4'h0;
    reg [31:0] wdata = 32'h0;
    reg wr = 1'b0, rd = 1'b0, even_cycle = 1'b0, ool = 1'b0, nm_start = 1'b0;
    reg [8:0] ev = 9'h0;
    reg [11:0] rc_val = 12'h0;
    reg [1:0] slm_in = 2'h0;
    reg [3:0] nm_count = 4'h0;
    wire [31:0] rdata;
    wire [3:0] poc_state, scnt;
    wire [11:0] rcv;
    wire [1:0] wus, brp;
    wire nm_busy, tx_en, slot_en, acc_en, lb_valid, irq;
    integer err_count = 0, check_count = 0;
    integer m_st, m_csi, m_slm, d, v, k, i;
    bpsc_ctl dut (
        .clock(clock), .srst(srst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .cycle_start(ev[0]), .even_cycle(even_cycle), .sync_frame_rx(ev[1]), .startup_frame_rx(ev[2]),
        .dyn_slot_tick(ev[3]), .dyn_seg_end(ev[4]), .idle_late(ev[5]), .rc_calc_valid(ev[6]),
        .rc_calc_value(rc_val), .pair_done(ev[7]), .offset_over_limit(ool), .startup_done(ev[8]),
        .wus_rx(wus), .slot_mode_in(slm_in), .poc_state(poc_state), .rate_correction_value(rcv),
        .startup_count(scnt), .tx_enable(tx_en), .slot_count_en(slot_en), .accept_filter_en(acc_en),
        .baud_prescaler(brp), .loopback_valid(lb_valid), .irq(irq));
    bpsc_node_model node (.clock(clock), .start(nm_start), .chan(2'h1), .count(nm_count), .wus_rx(wus),
        .busy(nm_busy));
    ////////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        begin
            if (err_count == 0 && check_count > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wr_reg(input [3:0] a, input [31:0] dd);
        begin
            @(posedge clock);
            addr <= a; wdata <= dd; wr <= 1'b1;
            @(posedge clock);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [3:0] a, input [31:0] m, input [31:0] e);
        begin
            @(posedge clock);
            addr <= a; rd <= 1'b1;
            @(posedge clock);
            rd <= 1'b0;
            #1 chk(rdata & m, e & m);
        end
    endtask
    task pulse(input [8:0] m);
        begin
            @(posedge clock);
            ev <= m;
            @(posedge clock);
            ev <= 9'h0;
        end
    endtask
    task send_wus(input [3:0] n);
        begin
            @(posedge clock);
            nm_count <= n; nm_start <= 1'b1;
            @(posedge clock);
            nm_start <= 1'b0;
            #1 for (i = 0; i < 60 && nm_busy; i = i + 1) @(posedge clock);
            repeat (4) @(posedge clock);
        end
    endtask
    task cmd(input [3:0] c);
        begin
            wr_reg(`BPSC_ADDR_CMD, {28'h0, c});
            if (c == `BPSC_CMD_CONFIG && m_st == 7) m_slm = 0;
            if (c == `BPSC_CMD_CONFIG) m_st = (m_st == 0) ? 1 : (m_st == 7) ? 0 : m_st;
            if (c == `BPSC_CMD_READY && m_st >= 1 && m_st <= 3) m_csi = 1;
            if (c == `BPSC_CMD_READY && m_st >= 1 && m_st <= 3) m_st = 2;
            if (c == `BPSC_CMD_ALLOW_COLDSTART && m_st == 2) m_csi = 0;
            if (c == `BPSC_CMD_WAKEUP && m_st == 2) m_st = 3;
            if (c == `BPSC_CMD_RUN && m_st == 2) m_st = 4;
            if ((c == `BPSC_CMD_HALT || c == `BPSC_CMD_FREEZE) && (m_st == 5 || m_st == 6)) m_st = 7;
            if (c == `BPSC_CMD_LOOPBACK && m_st == 1) m_st = 8;
        end
    endtask
    function automatic [31:0] stat_exp();
        stat_exp = m_st | (m_slm << 4) | (m_csi << 6);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 clock = ~clock;
    end
    initial begin
        #300000;
        err_count = err_count + 1;
        tally_and_finish;
    end
    initial begin
        m_st = 0; m_csi = 1; m_slm = 0;
        i = $urandom(32'hB926DB2C);
        d = 1 + $urandom % 200;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        rd_reg(`BPSC_ADDR_STAT, 32'hFFFFFFFF, 32'h40);
        rd_reg(4'hF, 32'hFFFFFFFF, 32'h0);
        cmd(`BPSC_CMD_RUN);
        rd_reg(`BPSC_ADDR_STAT, 32'h7F, stat_exp());
        cmd(`BPSC_CMD_CONFIG);
        for (k = 3; k >= 0; k = k - 1) begin
            wr_reg(`BPSC_ADDR_CFG, (d << 8) | k);
            #1 chk({30'h0, brp}, k);
        end
        wr_reg(`BPSC_ADDR_SYNC, 32'h2);
        wr_reg(`BPSC_ADDR_IRQ_MASK, 32'h1F);
        cmd(`BPSC_CMD_READY);
        cmd(`BPSC_CMD_ALLOW_COLDSTART);
        rd_reg(`BPSC_ADDR_STAT, 32'h7F, stat_exp());
        cmd(`BPSC_CMD_READY);
        rd_reg(`BPSC_ADDR_STAT, 32'h7F, stat_exp());
        cmd(`BPSC_CMD_WAKEUP);
        send_wus(4'h2);
        m_st = 2;
        chk({31'h0, irq}, 32'h1);
        rd_reg(`BPSC_ADDR_STAT, 32'h38F, 32'h82);
        rd_reg(`BPSC_ADDR_IRQ_STAT, 32'h1F, 32'h3);
        chk({31'h0, irq}, 32'h0);
        send_wus(4'h1);
        rd_reg(`BPSC_ADDR_IRQ_STAT, 32'h2, 32'h0);
        send_wus(4'h1);
        rd_reg(`BPSC_ADDR_IRQ_STAT, 32'h2, 32'h2);
        for (k = 0; k < 2; k = k + 1) begin
            if (m_st == 0) cmd(`BPSC_CMD_CONFIG);
            cmd(`BPSC_CMD_READY);
            cmd(`BPSC_CMD_RUN);
            if (k == 0) begin
                v = d + 1 + $urandom % 50;
                rc_val <= v[11:0];
                pulse(9'h040);
                rd_reg(`BPSC_ADDR_RCV, 32'hFFF, 32'h0);
                repeat (3) pulse(9'h001);
                pulse(9'h040);
                rd_reg(`BPSC_ADDR_RCV, 32'hFFF, v);
                i = $urandom % (d + 1);
                rc_val <= 12'h000 - i[11:0];
                pulse(9'h040);
                rd_reg(`BPSC_ADDR_RCV, 32'hFFF, 32'h0);
                even_cycle <= 1'b1;
                pulse(9'h001);
                pulse(9'h004);
                repeat (3) pulse(9'h002);
                pulse(9'h004);
                #1 chk(scnt, 1);
            end
            i = 1 + $urandom % 3;
            slm_in <= i[1:0];
            m_slm = i;
            pulse(9'h100);
            m_st = 5;
            rd_reg(`BPSC_ADDR_STAT, 32'h3F, stat_exp());
            if (k == 0) begin
                rd_reg(`BPSC_ADDR_IRQ_STAT, 32'h0, 32'h0);
                pulse(9'h001);
                repeat (2) pulse(9'h002);
                repeat (1030) pulse(9'h008);
                rd_reg(`BPSC_ADDR_IRQ_STAT, 32'h8, 32'h0);
                pulse(9'h020);
                #1 chk({30'h0, tx_en, slot_en}, 0);
                pulse(9'h010);
                #1 chk({30'h0, tx_en, slot_en}, 3);
            end
            cmd(k ? `BPSC_CMD_FREEZE : `BPSC_CMD_HALT);
            slm_in <= 2'h0;
            rd_reg(`BPSC_ADDR_STAT, 32'h3F, stat_exp());
            cmd(`BPSC_CMD_CONFIG);
            rd_reg(`BPSC_ADDR_STAT, 32'h3F, stat_exp());
        end
        cmd(`BPSC_CMD_CONFIG);
        cmd(`BPSC_CMD_LOOPBACK);
        repeat (2) @(posedge clock);
        #1 chk({28'h0, poc_state}, m_st);
        chk({31'h0, acc_en}, 32'h1);
        chk({31'h0, lb_valid}, 32'h1);
        @(posedge clock) srst <= 1'b1;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        m_st = 0; m_csi = 1; m_slm = 0;
        cmd(`BPSC_CMD_CONFIG);
        cmd(`BPSC_CMD_READY);
        cmd(`BPSC_CMD_RUN);
        ool <= 1'b1;
        pulse(9'h080);
        ool <= 1'b0;
        rd_reg(`BPSC_ADDR_IRQ_STAT, 32'h10, 32'h10);
        tally_and_finish;
    end
endmodule // bus_protocol_sync_startup_ctl_bench
bind bpsc_ctl bpsc_ctl_chk #(.RCW(RCW), .SYNCW(SYNCW)) u_chk (.*);
